// *** inc/can_filt_pkg.sv ***
// Constants, register map and carrier types of the CAN acceptance filter and status block.
`default_nettype none
package can_filt_pkg;

  // Register byte addresses on the Wishbone slave.
  localparam logic [7:0] OFS_FILT_CTRL = 8'h00;
  localparam logic [7:0] OFS_MISC = 8'h04;
  localparam logic [7:0] OFS_RX_ERR = 8'h08;
  localparam logic [7:0] OFS_TX_ERR = 8'h0c;
  localparam logic [7:0] OFS_MODE_CTRL = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // Acceptance codes at 0x20..0x3c and masks at 0x40..0x5c, one byte per word.
  localparam logic [2:0] PAGE_CODE = 3'h1;
  localparam logic [2:0] PAGE_MASK = 3'h2;

  // Field positions.
  localparam int MODE_LSB = 4;
  localparam int HIT_LSB = 0;
  localparam int HOLD_BIT = 0;
  localparam int CTRL_INIT_RQ = 0;
  localparam int CTRL_INIT_AK = 1;
  localparam int CTRL_SLP_RQ = 2;
  localparam int CTRL_SLP_AK = 3;
  localparam int CTRL_URS = 4;
  localparam int IRQ_ACCEPT = 0;
  localparam int IRQ_DROP = 1;
  localparam int IRQ_BUS_OFF = 2;
  localparam int IRQ_W = 3;

  // Values after reset.
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [2:0] HIT_RST = 3'h0;
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic INIT_RQ_RST = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // Filter organisation encodings.
  typedef enum logic [1:0] {
    ORG_TWO_32 = 2'h0,
    ORG_FOUR_16 = 2'h1,
    ORG_EIGHT_8 = 2'h2,
    ORG_CLOSED = 2'h3
  } filter_org_e;

  // A received identifier: byte 0 is bits 31:24.
  typedef struct packed {
    logic valid;
    logic ext;
    logic [31:0] id;
  } rx_msg_s;

  // A message moving into the foreground receive buffer with its stored hit number.
  typedef struct packed {
    logic load;
    logic [2:0] hit;
  } fg_load_s;

  // Whole state of the block.
  typedef struct packed {
    filter_org_e org;
    logic [2:0] hit;
    logic [7:0][7:0] code;
    logic [7:0][7:0] mask;
    logic init_rq;
    logic init_ak;
    logic slp_rq;
    logic slp_ak;
    logic urs;
    logic hold;
    logic bus_off_d;
    logic rec_req;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_msk;
    logic ack;
    logic [7:0] dat;
    logic acc;
    logic [2:0] acc_hit;
  } state_s;

endpackage : can_filt_pkg
`default_nettype wire

// *** rtl/can_filt_status.sv ***
// Acceptance filter, hit indication, bus-off hold and error counter view of a CAN controller.
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module can_filt_status (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive path.
  input wire can_filt_pkg::rx_msg_s rx_msg_i,
  input wire can_filt_pkg::fg_load_s fg_load_i,
  output logic rx_accept_o,
  output logic [2:0] rx_hit_o,
  // Protocol engine status.
  input wire logic bus_off_i,
  input wire logic [7:0] rx_err_cnt_i,
  input wire logic [7:0] tx_err_cnt_i,
  output logic recovery_req_o,
  // Interrupt.
  output logic irq_o
);

  can_filt_pkg::state_s st_r;
  can_filt_pkg::state_s st_nxt;
  logic init_mode;
  logic req;
  logic wr;
  logic [7:0] wdat;
  logic [7:0] match;
  logic any_match;
  logic [2:0] first_hit;
  logic hold_set;
  logic [3:0][7:0] idb;

  function automatic logic byte_ok(input logic [7:0] code_b, input logic [7:0] mask_b,
                                   input logic [7:0] id_b);
    byte_ok = &(~(code_b ^ id_b) | mask_b);
  endfunction : byte_ok

  assign init_mode = st_r.init_rq & st_r.init_ak;
  assign req = wb_cyc_i & wb_stb_i;
  // Writes commit on the edge at which the master samples ack.
  assign wr = req & wb_we_i & st_r.ack & wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];
  assign hold_set = st_r.urs & bus_off_i & ~st_r.bus_off_d;

  // Identifier bytes, byte 0 at the top of the word.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      idb[b] = rx_msg_i.id[31 - 8 * b -: 8];
    end
  end

  always_comb begin
    match = 8'h00;
    unique case (st_r.org)
      can_filt_pkg::ORG_TWO_32: begin
        for (int j = 0; j < 2; j++) begin
          match[j] = byte_ok(st_r.code[4 * j], st_r.mask[4 * j], idb[0])
            & byte_ok(st_r.code[4 * j + 1], st_r.mask[4 * j + 1], idb[1])
            & (~rx_msg_i.ext
               | (byte_ok(st_r.code[4 * j + 2], st_r.mask[4 * j + 2], idb[2])
                  & byte_ok(st_r.code[4 * j + 3], st_r.mask[4 * j + 3], idb[3])));
        end
      end
      can_filt_pkg::ORG_FOUR_16: begin
        for (int j = 0; j < 4; j++) begin
          match[j] = byte_ok(st_r.code[2 * j], st_r.mask[2 * j], idb[0])
            & byte_ok(st_r.code[2 * j + 1], st_r.mask[2 * j + 1], idb[1]);
        end
      end
      can_filt_pkg::ORG_EIGHT_8: begin
        for (int j = 0; j < 8; j++) begin
          match[j] = byte_ok(st_r.code[j], st_r.mask[j], idb[0]);
        end
      end
      can_filt_pkg::ORG_CLOSED: begin
        match = 8'h00;
      end
    endcase
  end

  always_comb begin
    first_hit = 3'h0;
    for (int j = 7; j >= 0; j--) begin
      if (match[j]) begin
        first_hit = 3'(j);
      end
    end
  end
  assign any_match = |match;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = req & ~st_r.ack;
    st_nxt.init_ak = st_r.init_rq;
    st_nxt.slp_ak = st_r.slp_rq;
    st_nxt.bus_off_d = bus_off_i;
    st_nxt.rec_req = 1'b0;
    // Every message is judged; rejected ones simply get overwritten upstream.
    st_nxt.acc = rx_msg_i.valid & any_match;
    st_nxt.acc_hit = rx_msg_i.valid ? first_hit : st_r.acc_hit;
    if (fg_load_i.load) begin
      st_nxt.hit = fg_load_i.hit;
    end
    // Register writes.
    if (wr) begin
      unique case (wb_adr_i[7:5])
        can_filt_pkg::PAGE_CODE: begin
          if (init_mode && wb_adr_i[1:0] == 2'h0) begin
            st_nxt.code[wb_adr_i[4:2]] = wdat;
          end
        end
        can_filt_pkg::PAGE_MASK: begin
          if (init_mode && wb_adr_i[1:0] == 2'h0) begin
            st_nxt.mask[wb_adr_i[4:2]] = wdat;
          end
        end
        default: begin
          if (wb_adr_i == can_filt_pkg::OFS_FILT_CTRL && init_mode) begin
            st_nxt.org = can_filt_pkg::filter_org_e'(wdat[can_filt_pkg::MODE_LSB +: 2]);
          end
          if (wb_adr_i == can_filt_pkg::OFS_MISC && wdat[can_filt_pkg::HOLD_BIT]) begin
            st_nxt.hold = 1'b0;
            st_nxt.rec_req = st_r.hold;
          end
          if (wb_adr_i == can_filt_pkg::OFS_MODE_CTRL) begin
            st_nxt.init_rq = wdat[can_filt_pkg::CTRL_INIT_RQ];
            st_nxt.slp_rq = wdat[can_filt_pkg::CTRL_SLP_RQ];
            st_nxt.urs = wdat[can_filt_pkg::CTRL_URS];
          end
          if (wb_adr_i == can_filt_pkg::OFS_IRQ_STATUS) begin
            st_nxt.irq_st = st_r.irq_st & ~wdat[can_filt_pkg::IRQ_W-1:0];
          end
          if (wb_adr_i == can_filt_pkg::OFS_IRQ_MASK) begin
            st_nxt.irq_msk = wdat[can_filt_pkg::IRQ_W-1:0];
          end
        end
      endcase
    end
    // Hardware events win over a clear in the same cycle.
    if (~bus_off_i) begin
      st_nxt.hold = 1'b0;
    end
    if (hold_set) begin
      st_nxt.hold = 1'b1;
      st_nxt.irq_st[can_filt_pkg::IRQ_BUS_OFF] = 1'b1;
    end
    if (st_r.acc) begin
      st_nxt.irq_st[can_filt_pkg::IRQ_ACCEPT] = 1'b1;
    end
    if (rx_msg_i.valid && !any_match) begin
      st_nxt.irq_st[can_filt_pkg::IRQ_DROP] = 1'b1;
    end
    // Read data is captured when the request is first seen.
    st_nxt.dat = 8'h00;
    if (req && !st_r.ack && !wb_we_i) begin
      unique case (wb_adr_i[7:5])
        can_filt_pkg::PAGE_CODE: begin
          st_nxt.dat = st_r.code[wb_adr_i[4:2]];
        end
        can_filt_pkg::PAGE_MASK: begin
          st_nxt.dat = st_r.mask[wb_adr_i[4:2]];
        end
        default: begin
          unique case (wb_adr_i)
            can_filt_pkg::OFS_FILT_CTRL: st_nxt.dat = {2'h0, st_r.org, 1'b0, st_r.hit};
            can_filt_pkg::OFS_MISC: st_nxt.dat = {7'h00, st_r.hold};
            // Counters are live; outside sleep or init they may be mid-update.
            can_filt_pkg::OFS_RX_ERR: st_nxt.dat = rx_err_cnt_i;
            can_filt_pkg::OFS_TX_ERR: st_nxt.dat = tx_err_cnt_i;
            can_filt_pkg::OFS_MODE_CTRL: st_nxt.dat = {3'h0, st_r.urs, st_r.slp_ak,
                                                       st_r.slp_rq, st_r.init_ak, st_r.init_rq};
            can_filt_pkg::OFS_IRQ_STATUS: st_nxt.dat = {5'h00, st_r.irq_st};
            can_filt_pkg::OFS_IRQ_MASK: st_nxt.dat = {5'h00, st_r.irq_msk};
            default: st_nxt.dat = 8'h00;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.org <= can_filt_pkg::filter_org_e'(can_filt_pkg::MODE_RST);
      st_r.hit <= can_filt_pkg::HIT_RST;
      st_r.code <= {8{can_filt_pkg::CODE_RST}};
      st_r.mask <= {8{can_filt_pkg::MASK_RST}};
      st_r.init_rq <= can_filt_pkg::INIT_RQ_RST;
      st_r.irq_st <= can_filt_pkg::IRQ_RST;
      st_r.irq_msk <= can_filt_pkg::IRQ_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = {24'h000000, st_r.dat};
  assign rx_accept_o = st_r.acc;
  assign rx_hit_o = st_r.acc_hit;
  assign recovery_req_o = st_r.rec_req;
  assign irq_o = |(st_r.irq_st & st_r.irq_msk);

  // Checks.
  property p_org_locked;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.org != $past(st_r.org)) |-> $past(init_mode);
  endproperty
  a_org_locked: assert property (p_org_locked) else $error("organisation changed outside init");

  property p_closed;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.org == can_filt_pkg::ORG_CLOSED && rx_msg_i.valid) |=> !rx_accept_o;
  endproperty
  a_closed: assert property (p_closed) else $error("closed filter accepted a message");

  property p_hit_follow;
    @(posedge clk_i) disable iff (rst_i)
      fg_load_i.load |=> (st_r.hit == $past(fg_load_i.hit));
  endproperty
  a_hit_follow: assert property (p_hit_follow) else $error("hit not updated on load");

  property p_w1c;
    @(posedge clk_i) disable iff (rst_i)
      (wr && wb_adr_i == can_filt_pkg::OFS_MISC && wdat[0] && st_r.hold && !hold_set)
        |=> !st_r.hold && recovery_req_o;
  endproperty
  a_w1c: assert property (p_w1c) else $error("hold not cleared by one");

  property p_hold_set;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.urs && $rose(bus_off_i))
        |=> st_r.hold ##1 (st_r.hold || $past(!bus_off_i) || $past(wr));
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("bus-off hold not held");

  property p_hold_zero;
    @(posedge clk_i) disable iff (rst_i)
      !bus_off_i |=> !st_r.hold;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("hold set while not bus-off");

  property p_code_locked;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.code != $past(st_r.code)) |-> $past(init_mode);
  endproperty
  a_code_locked: assert property (p_code_locked) else $error("code written outside init");

  property p_byte_filter;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.org == can_filt_pkg::ORG_EIGHT_8 && rx_msg_i.valid
       && ((rx_msg_i.id[31:24] ^ st_r.code[0]) & ~st_r.mask[0]) == 8'h00)
        |=> rx_accept_o && rx_hit_o == 3'h0;
  endproperty
  a_byte_filter: assert property (p_byte_filter) else $error("filter 0 match missed");

  property p_std_two_bytes;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.org == can_filt_pkg::ORG_TWO_32 && rx_msg_i.valid && !rx_msg_i.ext
       && rx_msg_i.id[31:16] == {st_r.code[0], st_r.code[1]}) |=> rx_accept_o;
  endproperty
  a_std_two_bytes: assert property (p_std_two_bytes) else $error("standard frame rejected");

  property p_ack_drop;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");

  // Bus handshake, read data and mode acknowledges.
  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");

  property p_dat_idle;
    @(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> (wb_dat_o == 32'h00000000);
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside acknowledge");

  property p_mode_ack;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (st_r.slp_ak == $past(st_r.slp_rq)) && (st_r.init_ak == $past(st_r.init_rq));
  endproperty
  a_mode_ack: assert property (p_mode_ack) else $error("mode acknowledge lags request");

  property p_mask_locked;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.mask != $past(st_r.mask)) |-> $past(init_mode);
  endproperty
  a_mask_locked: assert property (p_mask_locked) else $error("mask written outside init");

  property p_hit_readonly;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.hit != $past(st_r.hit)) |-> $past(fg_load_i.load);
  endproperty
  a_hit_readonly: assert property (p_hit_readonly) else $error("hit moved without load");

  property p_accept_pulse;
    @(posedge clk_i) disable iff (rst_i)
      rx_accept_o |-> $past(rx_msg_i.valid);
  endproperty
  a_accept_pulse: assert property (p_accept_pulse) else $error("accept without message");

  property p_hit_hold;
    @(posedge clk_i) disable iff (rst_i)
      !rx_msg_i.valid |=> $stable(rx_hit_o);
  endproperty
  a_hit_hold: assert property (p_hit_hold) else $error("hit export moved");

  property p_closed_drop;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.org == can_filt_pkg::ORG_CLOSED && rx_msg_i.valid)
        |=> st_r.irq_st[can_filt_pkg::IRQ_DROP];
  endproperty
  a_closed_drop: assert property (p_closed_drop) else $error("drop not flagged");

  property p_accept_irq;
    @(posedge clk_i) disable iff (rst_i)
      rx_accept_o |=> st_r.irq_st[can_filt_pkg::IRQ_ACCEPT];
  endproperty
  a_accept_irq: assert property (p_accept_irq) else $error("accept not flagged");

  property p_irq_quiet;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.irq_msk == 3'h0) |-> !irq_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt with all sources masked");

  property p_rec_pulse;
    @(posedge clk_i) disable iff (rst_i)
      recovery_req_o |=> !recovery_req_o;
  endproperty
  a_rec_pulse: assert property (p_rec_pulse) else $error("recovery request held");

  property p_hold_urs;
    @(posedge clk_i) disable iff (rst_i)
      $rose(st_r.hold) |-> $past(st_r.urs);
  endproperty
  a_hold_urs: assert property (p_hold_urs) else $error("hold set without user recovery");

  c_accept: cover property (@(posedge clk_i) disable iff (rst_i) rx_accept_o && rx_hit_o == 3'h7);
  c_hold: cover property (@(posedge clk_i) disable iff (rst_i) recovery_req_o);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  c_closed_drop: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r.org == can_filt_pkg::ORG_CLOSED && rx_msg_i.valid);
  c_sixteen: cover property (@(posedge clk_i) disable iff (rst_i)
    rx_accept_o && st_r.org == can_filt_pkg::ORG_FOUR_16);

endmodule : can_filt_status
`default_nettype wire

// *** dv/can_node_model.sv ***
// Behavioural stand-in for the protocol engine and the other nodes on the CAN bus.
`timescale 1ns/100ps
`default_nettype none
module can_node_model (
  // Clock.
  input wire logic clk_i,
  // Towards the filter block.
  output can_filt_pkg::rx_msg_s rx_msg_o,
  output logic bus_off_o,
  output logic [7:0] rx_err_o,
  output logic [7:0] tx_err_o
);
  initial begin
    rx_msg_o = '0;
    bus_off_o = 1'b0;
    rx_err_o = 8'h00;
    tx_err_o = 8'h80;
  end
  // Every frame is handed over, accepted or not; after it the id lines toggle so stale ids show.
  task automatic send(input logic ext, input logic [31:0] id);
    @(posedge clk_i);
    rx_msg_o <= {1'b1, ext, id};
    rx_err_o <= rx_err_o + 8'h01;
    tx_err_o <= tx_err_o - 8'h01;
    @(posedge clk_i);
    rx_msg_o <= {1'b0, ext, ~id};
  endtask : send
  task automatic go_bus_off();
    @(posedge clk_i);
    bus_off_o <= 1'b1;
  endtask : go_bus_off
endmodule : can_node_model
`default_nettype wire

// *** dv/can_filt_status_test.sv ***
// Self-checking testbench of the CAN acceptance filter and status block.
`timescale 1ns/100ps
`default_nettype none
module can_filt_status_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  can_filt_pkg::rx_msg_s rx_msg;
  can_filt_pkg::fg_load_s fg_load = '0;
  logic rx_accept_o;
  logic [2:0] rx_hit_o;
  logic bus_off;
  logic [7:0] rx_err;
  logic [7:0] tx_err;
  logic recovery_req_o;
  logic irq_o;
  int errors = 0;
  int total_checks = 0;
  int recoveries = 0;
  int seed = 32'h6f2143dd;
  logic [7:0] code [8];
  logic [7:0] mask [8];
  logic [7:0] rd;
  logic [2:0] hit_fg;
  logic [31:0] id;
  logic ext;
  logic [3:0] exp;
  int a;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) if (recovery_req_o === 1'b1) recoveries++;

  can_filt_status u_can_filt_status (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_msg_i(rx_msg), .fg_load_i(fg_load),
    .rx_accept_o(rx_accept_o), .rx_hit_o(rx_hit_o), .bus_off_i(bus_off),
    .rx_err_cnt_i(rx_err), .tx_err_cnt_i(tx_err), .recovery_req_o(recovery_req_o),
    .irq_o(irq_o)
  );
  can_node_model u_can_node_model (
    .clk_i(clk_i), .rx_msg_o(rx_msg), .bus_off_o(bus_off), .rx_err_o(rx_err),
    .tx_err_o(tx_err)
  );

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] got);
    total_checks++;
    if (got !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask : chk_byte
  task automatic chk_bit(input string what, input logic e, input logic got);
    chk_byte(what, {7'h0, e}, {7'h0, got});
  endtask : chk_bit
  // Single classic cycle; the answer is awaited, never assumed.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd_chk(input string what, input logic [7:0] adr, input logic [7:0] e);
    wb(1'b0, adr, 8'h00);
    chk_byte(what, e, rd);
  endtask : rd_chk
  // Returns accept and lowest matching filter; filters scan downwards so the lowest wins.
  function automatic logic [3:0] filt(input int org, input logic x, input logic [31:0] v);
    int w;
    logic ok;
    filt = 4'h0;
    if (org == 3) return 4'h0;
    w = (org == 0) ? (x ? 4 : 2) : (org == 1) ? 2 : 1;
    for (int f = (2 << org) - 1; f >= 0; f--) begin
      ok = 1'b1;
      for (int k = 0; k < w; k++)
        ok &= &(~(code[f * (4 >> org) + k] ^ v[31 - 8 * k -: 8]) | mask[f * (4 >> org) + k]);
      if (ok) filt = {1'b1, f[2:0]};
    end
  endfunction : filt
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("filter control", 8'h00, 8'h00);
    rd_chk("misc", 8'h04, 8'h00);
    rd_chk("mode", 8'h10, 8'h03);
    @(posedge clk_i);
    fg_load <= '{1'b1, 3'h5};
    @(posedge clk_i);
    fg_load <= '{1'b0, 3'h2};
    hit_fg = 3'h5;
    for (int k = 0; k < 8; k++) begin
      code[k] = 8'($random(seed));
      mask[k] = 8'($random(seed) | $random(seed));
      wb(1'b1, 8'h20 + 8'(4 * k), code[k]);
      wb(1'b1, 8'h40 + 8'(4 * k), mask[k]);
      rd_chk("code", 8'h20 + 8'(4 * k), code[k]);
      rd_chk("mask", 8'h40 + 8'(4 * k), mask[k]);
    end
    for (int o = 3; o >= 0; o--) begin
      wb(1'b1, 8'h00, {2'h0, 2'(o), 4'h7});
      rd_chk("filter control", 8'h00, {2'h0, 2'(o), 1'b0, hit_fg});
      repeat (40) begin
        a = 4 * ($random(seed) & 1);
        ext = 1'($random(seed));
        id = $random(seed);
        // Half the ids are near misses or exact copies of a stored code.
        if (id[0]) id = {code[a], code[a + 1], code[a + 2], code[a + 3]} ^ (32'h1 << id[6:1]);
        exp = filt(o, ext, id);
        u_can_node_model.send(ext, id);
        #1;
        chk_bit("accept", exp[3], rx_accept_o);
        if (exp[3]) chk_byte("hit", {5'h0, exp[2:0]}, {5'h0, rx_hit_o});
      end
    end
    rd_chk("irq status", 8'h14, 8'h03);
    rd_chk("rx errors", 8'h08, rx_err);
    rd_chk("tx errors", 8'h0c, tx_err);
    wb(1'b1, 8'h10, 8'h14);
    rd_chk("mode", 8'h10, 8'h1c);
    wb(1'b1, 8'h20, ~code[0]);
    rd_chk("code", 8'h20, code[0]);
    wb(1'b1, 8'h00, 8'h30);
    rd_chk("filter control", 8'h00, {5'h0, hit_fg});
    wb(1'b1, 8'h18, 8'h04);
    wb(1'b1, 8'h14, 8'h07);
    u_can_node_model.go_bus_off();
    repeat (3) @(posedge clk_i);
    rd_chk("misc", 8'h04, 8'h01);
    chk_bit("irq", 1'b1, irq_o);
    wb(1'b1, 8'h04, 8'h00);
    rd_chk("misc", 8'h04, 8'h01);
    wb(1'b1, 8'h04, 8'h01);
    rd_chk("misc", 8'h04, 8'h00);
    chk_byte("recoveries", 8'h01, 8'(recoveries));
    wb(1'b1, 8'h14, 8'h04);
    @(posedge clk_i);
    #1;
    chk_bit("irq", 1'b0, irq_o);
    rd_chk("unmapped", 8'hfc, 8'h00);
    results();
  end
  // The whole sequence needs a few hundred cycles; this bound only cuts a hang.
  initial begin
    #400000;
    errors++;
    results();
  end
endmodule : can_filt_status_test
`default_nettype wire
